/* rtl/sae_actuator_enables.sv */
// Actuator enable command interpreter with Avalon-MM register access
`timescale 1ns/10ps
module sae_actuator_enables #(
  parameter int NUM_ACT = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Command status
  output logic busy_o,
  output logic done_o,
  output logic [7:0] result_code_o
);
  // Index width for actuator selection
  localparam int IW = (NUM_ACT > 1) ? $clog2(NUM_ACT) : 1;
  // Members per actuator
  localparam int MB = sae_pkg::SAE_MAX_MEMBERS;

  // Register map, byte addresses
  // CTRL 00: bit0 start, bit1 flush, bit2 clear reject
  // REQ 04: append one request byte
  // STATUS 08: busy, done, reject, overflow, count, result
  // SET 0C: direct member value change
  // CFG 40+4i: handle, default flag, default value
  // OPS 80+4i: op states and event enables
  // VAL C0+4n: member values
  // Unmapped reads give zero, writes are dropped
  // Every access takes exactly one wait cycle

  // Whole state of the block
  typedef struct packed {
    // Command engine state
    sae_pkg::sae_state_t st;
    // Bus answer pending
    logic ack;
    // Captured read data
    logic [31:0] rdata;
    // Request byte buffer
    logic [sae_pkg::SAE_REQ_BYTES-1:0][7:0] rbuf;
    // Bytes held in the buffer
    logic [4:0] cnt;
    // Too many request bytes
    logic ovf;
    // Command finished
    logic done;
    // Last result code
    logic [7:0] rc;
    // Sticky refused direct change
    logic rej;
    // Descriptor record words
    logic [NUM_ACT-1:0][31:0] cfg;
    // Member operational states
    logic [NUM_ACT-1:0][MB-1:0][1:0] op;
    // Member event report enables
    logic [NUM_ACT-1:0][MB-1:0] ev;
    // Member state values
    logic [NUM_ACT-1:0][MB-1:0][7:0] val;
  } sae_regs_t;

  sae_regs_t s_r; // Registered state
  sae_regs_t s_nxt; // Next state

  // Bus handshake: one wait cycle, then answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_r.ack;
  // Read data from the capture register
  assign avs_readdata_o = s_r.rdata;
  // Engine busy for exactly one cycle
  assign busy_o = (s_r.st == sae_pkg::SAE_EXEC);
  // Done stays until the next start
  assign done_o = s_r.done;
  // Last result code held
  assign result_code_o = s_r.rc;

  // Next-state logic: bus, request buffer and command engine
  always_comb begin
    // Byte lane mask for descriptor writes
    logic [31:0] wmask;
    // Handle from the first two request bytes
    logic [15:0] handle;
    // Composite set count byte
    logic [7:0] count;
    // Operation byte under test
    logic [7:0] opv;
    // Event byte under test
    logic [7:0] evv;
    // Index of the matched actuator
    logic [IW-1:0] idx;
    // Handle matched an actuator
    logic hit;
    // Every counted field holds a legal code
    logic fields_ok;
    // Actuator picked by a direct write
    logic [IW-1:0] sa;
    // Member picked by a direct write
    logic [2:0] sm;
    s_nxt = s_r;
    // Byte lanes to bit mask
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Header fields from the request buffer
    handle = {s_r.rbuf[1], s_r.rbuf[0]};
    count = s_r.rbuf[2];
    // Work variables start cleared, except fields_ok which starts set
    opv = 8'h00;
    evv = 8'h00;
    idx = '0;
    hit = 1'b0;
    fields_ok = 1'b1;
    sa = '0;
    sm = 3'h0;
    // Acknowledge each request one cycle after it rises
    s_nxt.ack = (avs_read_i | avs_write_i) & ~s_r.ack;
    // Read data captured in the wait cycle
    if (avs_read_i & ~s_r.ack) begin
      // Unmapped addresses read zero
      s_nxt.rdata = 32'h0000_0000;
      if (avs_address_i == sae_pkg::SAE_OFF_STAT) begin
        // Status: busy, done, reject, overflow, count, result
        s_nxt.rdata[0] = (s_r.st == sae_pkg::SAE_EXEC);
        s_nxt.rdata[1] = s_r.done;
        s_nxt.rdata[2] = s_r.rej;
        s_nxt.rdata[3] = s_r.ovf;
        s_nxt.rdata[8 +: 5] = s_r.cnt;
        s_nxt.rdata[16 +: 8] = s_r.rc;
      end
      for (int i = 0; i < NUM_ACT; i++) begin
        // Per actuator configuration and settings
        if (avs_address_i == 8'(sae_pkg::SAE_OFF_CFG + 4 * i)) begin
          s_nxt.rdata = s_r.cfg[i];
        end
        if (avs_address_i == 8'(sae_pkg::SAE_OFF_OPS + 4 * i)) begin
          s_nxt.rdata[15:0] = s_r.op[i];
          s_nxt.rdata[23:16] = s_r.ev[i];
        end
        for (int m = 0; m < MB; m++) begin
          // Member state value words
          if (avs_address_i == 8'(sae_pkg::SAE_OFF_VAL + 4 * (i * MB + m))) begin
            s_nxt.rdata[7:0] = s_r.val[i][m];
          end
        end
      end
    end
    // Writes take effect on the acknowledge cycle
    if (avs_write_i & s_r.ack) begin
      // Control word: start, flush, clear reject
      if (avs_address_i == sae_pkg::SAE_OFF_CTRL && avs_byteenable_i[0]) begin
        // Start only when idle
        if (avs_writedata_i[sae_pkg::SAE_CTRL_START] && s_r.st == sae_pkg::SAE_IDLE) begin
          s_nxt.st = sae_pkg::SAE_EXEC;
          s_nxt.done = 1'b0;
        end
        // Flush the request buffer
        if (avs_writedata_i[sae_pkg::SAE_CTRL_FLUSH] && s_r.st == sae_pkg::SAE_IDLE) begin
          s_nxt.cnt = 5'h00;
          s_nxt.ovf = 1'b0;
        end
        // Clear reject flag
        if (avs_writedata_i[sae_pkg::SAE_CTRL_CLRREJ]) begin
          s_nxt.rej = 1'b0;
        end
      end else if (avs_address_i == sae_pkg::SAE_OFF_REQ && avs_byteenable_i[0]) begin
        // Append one request byte; extra bytes mark overflow
        if (s_r.st == sae_pkg::SAE_IDLE) begin
          if (s_r.cnt < 5'(sae_pkg::SAE_REQ_BYTES)) begin
            // Free slot: store the byte and count it
            s_nxt.rbuf[s_r.cnt] = avs_writedata_i[7:0];
            s_nxt.cnt = s_r.cnt + 5'h01;
          end else begin
            // Buffer full: drop the byte, flag overflow
            s_nxt.ovf = 1'b1;
          end
        end
      end else if (avs_address_i == sae_pkg::SAE_OFF_SET && avs_byteenable_i[0]) begin
        // Direct state change: [IW-1:0] actuator, [10:8] member, [23:16] value
        sa = avs_writedata_i[IW-1:0];
        sm = avs_writedata_i[10:8];
        // Indices beyond the last actuator are ignored
        if (32'(sa) < 32'(NUM_ACT)) begin
          // Only an enabled member takes a new value
          if (s_r.op[sa][sm] == sae_pkg::SAE_OP_ENABLED[1:0]) begin
            s_nxt.val[sa][sm] = avs_writedata_i[23:16];
          end else begin
            s_nxt.rej = 1'b1;
          end
        end
      end else begin
        for (int i = 0; i < NUM_ACT; i++) begin
          // Descriptor record words, byte lanes honoured
          if (avs_address_i == 8'(sae_pkg::SAE_OFF_CFG + 4 * i)) begin
            s_nxt.cfg[i] = (s_r.cfg[i] & ~wmask) | (avs_writedata_i & wmask);
          end
        end
      end
    end
    // Command engine: validate then apply in one cycle
    case (s_r.st)
      sae_pkg::SAE_IDLE: begin
        // Nothing to do until a start arrives
      end
      sae_pkg::SAE_EXEC: begin
        // Look up the handle; reserved values never match
        for (int i = NUM_ACT - 1; i >= 0; i--) begin
          if (s_r.cfg[i][15:0] == handle) begin
            hit = 1'b1;
            idx = IW'(i);
          end
        end
        if (handle == sae_pkg::SAE_HANDLE_RSV_LO || handle == sae_pkg::SAE_HANDLE_RSV_HI) begin
          hit = 1'b0;
        end
        // Check each counted operation field
        for (int m = 0; m < MB; m++) begin
          if (8'(m) < count) begin
            opv = s_r.rbuf[sae_pkg::SAE_HDR_BYTES + 2 * m];
            evv = s_r.rbuf[sae_pkg::SAE_HDR_BYTES + 2 * m + 1];
            if (opv != sae_pkg::SAE_OP_ENABLED && opv != sae_pkg::SAE_OP_DISABLED &&
                opv != sae_pkg::SAE_OP_UNAVAIL) begin
              fields_ok = 1'b0;
            end
            if (evv != sae_pkg::SAE_EV_ON && evv != sae_pkg::SAE_EV_OFF &&
                evv != sae_pkg::SAE_EV_KEEP) begin
              fields_ok = 1'b0;
            end
          end
        end
        // Single execution cycle, then report
        s_nxt.st = sae_pkg::SAE_IDLE;
        s_nxt.done = 1'b1;
        if (s_r.cnt < 5'(sae_pkg::SAE_HDR_BYTES)) begin
          // Too short to hold a full header
          s_nxt.rc = sae_pkg::SAE_RC_BAD_LEN;
        end else if (!hit) begin
          // Unknown or reserved handle
          s_nxt.rc = sae_pkg::SAE_RC_BAD_HANDLE;
        end else if (count < sae_pkg::SAE_CNT_MIN || count > sae_pkg::SAE_CNT_MAX ||
                     s_r.ovf ||
                     {3'h0, s_r.cnt} != 8'(sae_pkg::SAE_HDR_BYTES) + (count << 1)) begin
          // Count, overflow or length wrong
          s_nxt.rc = sae_pkg::SAE_RC_BAD_LEN;
        end else if (!fields_ok) begin
          // Unknown op or event code
          s_nxt.rc = sae_pkg::SAE_RC_BAD_DATA;
        end else begin
          // All checks passed
          s_nxt.rc = sae_pkg::SAE_RC_SUCCESS;
          // Apply fields to members 0 upward in request order
          for (int m = 0; m < MB; m++) begin
            if (8'(m) < count) begin
              opv = s_r.rbuf[sae_pkg::SAE_HDR_BYTES + 2 * m];
              evv = s_r.rbuf[sae_pkg::SAE_HDR_BYTES + 2 * m + 1];
              s_nxt.op[idx][m] = opv[1:0];
              // Return to default on entry to disabled
              if (opv == sae_pkg::SAE_OP_DISABLED &&
                  s_r.op[idx][m] != sae_pkg::SAE_OP_DISABLED[1:0] &&
                  s_r.cfg[idx][sae_pkg::SAE_CFG_HASDEF]) begin
                s_nxt.val[idx][m] = s_r.cfg[idx][sae_pkg::SAE_CFG_DEFLSB +: 8];
              end
              // Event report control
              if (evv == sae_pkg::SAE_EV_ON) begin
                s_nxt.ev[idx][m] = 1'b1;
              end else if (evv == sae_pkg::SAE_EV_OFF) begin
                s_nxt.ev[idx][m] = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        // Unreachable code returns to idle
        s_nxt.st = sae_pkg::SAE_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Engine idle, bus not acknowledged
      s_r.st <= sae_pkg::SAE_IDLE;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      // Request buffer empty
      s_r.rbuf <= '0;
      s_r.cnt <= 5'h00;
      s_r.ovf <= 1'b0;
      // No result pending
      s_r.done <= 1'b0;
      s_r.rc <= sae_pkg::SAE_RC_SUCCESS;
      s_r.rej <= 1'b0;
      // Descriptor records blank, handle matches nothing
      s_r.cfg <= {NUM_ACT{sae_pkg::SAE_RST_CFG}};
      // Members enabled, events off, values cleared
      s_r.op <= {(NUM_ACT * MB){sae_pkg::SAE_RST_OP}};
      s_r.ev <= '0;
      s_r.val <= {(NUM_ACT * MB){sae_pkg::SAE_RST_VAL}};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sae_actuator_enables

/* pkg/sae_pkg.sv */
// Constants and types for the actuator enable command block
// Notes on behaviour
// - Enable/disable actuators; disabled ones refuse state changes
// - Disabling may return member to default state
// - Default state only when descriptor record declares it
// - Request starts with 16-bit handle; 0000/FFFF reserved
// - At most eight members, offsets 0 to 7
// - One operation field per counted member
// - Op state: enabled, disabled=2, unavailable
// - Op state codes match the state read command
// - Event byte turns reports on/off; FF keeps
// - Answer is one result code byte, 80 bad handle
package sae_pkg;
  // Register byte offsets
  localparam logic [7:0] SAE_OFF_CTRL = 8'h00;
  localparam logic [7:0] SAE_OFF_REQ = 8'h04;
  localparam logic [7:0] SAE_OFF_STAT = 8'h08;
  localparam logic [7:0] SAE_OFF_SET = 8'h0C;
  localparam logic [7:0] SAE_OFF_CFG = 8'h40;
  localparam logic [7:0] SAE_OFF_OPS = 8'h80;
  localparam logic [7:0] SAE_OFF_VAL = 8'hC0;
  // Control bit positions
  localparam int SAE_CTRL_START = 0;
  localparam int SAE_CTRL_FLUSH = 1;
  localparam int SAE_CTRL_CLRREJ = 2;
  // Configuration word fields
  localparam int SAE_CFG_HASDEF = 16;
  localparam int SAE_CFG_DEFLSB = 24;
  // Request layout
  localparam int SAE_HDR_BYTES = 3;
  localparam int SAE_MAX_MEMBERS = 8;
  localparam int SAE_REQ_BYTES = 19;
  localparam logic [7:0] SAE_CNT_MIN = 8'h01;
  localparam logic [7:0] SAE_CNT_MAX = 8'h08;
  // Reserved handles
  localparam logic [15:0] SAE_HANDLE_RSV_LO = 16'h0000;
  localparam logic [15:0] SAE_HANDLE_RSV_HI = 16'hFFFF;
  // Operational state codes, shared with the state read command
  localparam logic [7:0] SAE_OP_ENABLED = 8'h01;
  localparam logic [7:0] SAE_OP_DISABLED = 8'h02;
  localparam logic [7:0] SAE_OP_UNAVAIL = 8'h03;
  // Event report control codes
  localparam logic [7:0] SAE_EV_ON = 8'h00;
  localparam logic [7:0] SAE_EV_OFF = 8'h01;
  localparam logic [7:0] SAE_EV_KEEP = 8'hFF;
  // Result codes
  localparam logic [7:0] SAE_RC_SUCCESS = 8'h00;
  localparam logic [7:0] SAE_RC_BAD_DATA = 8'h02;
  localparam logic [7:0] SAE_RC_BAD_LEN = 8'h03;
  localparam logic [7:0] SAE_RC_BAD_HANDLE = 8'h80;
  // Reset values
  localparam logic [1:0] SAE_RST_OP = 2'h1;
  localparam logic [7:0] SAE_RST_VAL = 8'h00;
  localparam logic [31:0] SAE_RST_CFG = 32'h0000_0000;
  // Command engine states
  typedef enum logic [0:0] {SAE_IDLE, SAE_EXEC} sae_state_t;
endpackage

/* testbench/sae_actuator_enables_monitor.sv */
// Port checker for the actuator enable block
`timescale 1ns/10ps
module sae_actuator_enables_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Status
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [7:0] result_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Accepted start write while idle
  wire logic go = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
    && avs_writedata_i[0] && avs_byteenable_i[0] && !busy_o;
  wire logic req = avs_read_i || avs_write_i;
  AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle");
  AST_ACK_NEXT: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o || !req)
    else $error("late bus answer");
  AST_START_BUSY: assert property (go |-> ##[1:2] (busy_o && !done_o))
    else $error("start not executed");
  AST_BUSY_ONE: assert property (busy_o |=> !busy_o && done_o)
    else $error("execution not single cycle");
  AST_DONE_CAUSE: assert property ($rose(done_o) |-> $past(busy_o))
    else $error("done without execution");
  AST_RC_LEGAL: assert property (done_o |-> result_code_o inside {8'h00, 8'h02, 8'h03, 8'h80})
    else $error("unknown result code");
  AST_RC_STABLE: assert property (done_o && $past(done_o) |-> $stable(result_code_o))
    else $error("result moved while done");
  AST_STAT_MIRROR: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == 8'h08 && !busy_o && !$past(busy_o) && !$past(busy_o, 2)
    |-> avs_readdata_o[23:16] == result_code_o && avs_readdata_o[1] == done_o)
    else $error("status differs from ports");
  // Main scenarios reached
  cover property (go);
  cover property (done_o && result_code_o == 8'h80);
  cover property (done_o && result_code_o == 8'h00);
endmodule // sae_actuator_enables_monitor

bind sae_actuator_enables sae_actuator_enables_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .busy_o(busy_o), .done_o(done_o), .result_code_o(result_code_o));

/* testbench/sae_requester.sv */
// Requester model that issues commands over the register bus
`timescale 1ns/10ps
module sae_requester (
  // Clock and slave answer
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  // Request
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  // Idle bus at time zero
  initial {addr_o, rd_o, wr_o, wdata_o, be_o} = '0;
  // One transfer, held until the rising edge that sees wait low
  task automatic xfer(input logic r, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    {addr_o, rd_o, wr_o, wdata_o, be_o} <= {a, r, !r, d, 4'hF};
    do @(posedge clk_i); while (wait_i);
    // Read data taken at the answering edge
    q = rdata_i;
    // Released lines show garbage
    {addr_o, rd_o, wr_o, wdata_o} <= {~a, 1'b0, 1'b0, ~d};
  endtask
  // Flush, header, fields, start, then poll for done
  task automatic cmd(input logic [15:0] h, input logic [7:0] n, input int nf,
    input logic [127:0] f, output logic [7:0] rc);
    logic [31:0] q;
    int k;
    xfer(0, 8'h00, 32'h2, q);
    xfer(0, 8'h04, {24'h0, h[7:0]}, q);
    xfer(0, 8'h04, {24'h0, h[15:8]}, q);
    xfer(0, 8'h04, {24'h0, n}, q);
    for (k = 0; k < 2 * nf; k++) xfer(0, 8'h04, {24'h0, f[8*k+:8]}, q);
    xfer(0, 8'h00, 32'h1, q);
    k = 0;
    do begin
      xfer(1, 8'h08, 32'h0, q);
      k++;
    end while (q[1] !== 1'b1 && k < 40);
    rc = q[23:16];
  endtask
endmodule // sae_requester

/* testbench/test_sae_actuator_enables.sv */
// Self-checking bench for the actuator enable block
`timescale 1ns/10ps
module test_sae_actuator_enables;
  // Clock, reset, bus and status wires
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr, rc, rcv;
  logic rd, wr, waitr, busy, done;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  int mismatches = 0, num_checks = 0, cyc = 0, i;
  // Row: handle, count, fields sent, fields, result, member word of actuator 0
  typedef struct {logic [15:0] h; logic [7:0] n; int nf; logic [127:0] f;
    logic [7:0] rc; logic [31:0] ops;} sae_row_t;
  sae_row_t rows[9] = '{'{16'h0123, 8'h01, 1, 128'h0002, 8'h00, 32'h0001_5556},
    '{16'h0000, 8'h01, 1, 128'h0001, 8'h80, 32'h0001_5556},
    '{16'hFFFF, 8'h01, 1, 128'h0001, 8'h80, 32'h0001_5556},
    '{16'h0999, 8'h01, 1, 128'h0001, 8'h80, 32'h0001_5556},
    '{16'h0123, 8'h00, 0, 128'h0, 8'h03, 32'h0001_5556},
    '{16'h0123, 8'h09, 8, 128'h0, 8'h03, 32'h0001_5556},
    '{16'h0123, 8'h02, 1, 128'h0001, 8'h03, 32'h0001_5556},
    '{16'h0123, 8'h01, 1, 128'h0504, 8'h02, 32'h0001_5556},
    '{16'h0123, 8'h08, 8, {{7{16'h0103}}, 16'hFF01}, 8'h00, 32'h0001_FFFD}};
  always #25 clk_i = ~clk_i;
  sae_actuator_enables i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitr), .busy_o(busy), .done_o(done),
    .result_code_o(rc));
  sae_requester i_req (.clk_i(clk_i), .rdata_i(rdat), .wait_i(waitr), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd), .be_o(be));
  // Compare tasks
  task automatic chk_rc(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t code %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t word %h want %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    i_req.xfer(0, 8'h40, 32'h5A01_0123, q);
    i_req.xfer(0, 8'h44, 32'h0000_0456, q);
    for (i = 0; i < 9; i++) begin
      i_req.cmd(rows[i].h, rows[i].n, rows[i].nf, rows[i].f, rcv);
      chk_rc(rcv, rows[i].rc);
      chk_rc(rc, rows[i].rc);
      chk_word({31'h0, done}, 32'h1);
      i_req.xfer(1, 8'h80, 32'h0, q);
      chk_word(q, rows[i].ops);
      $display("row %0d done", i);
    end
    i_req.xfer(1, 8'hC0, 32'h0, q);
    chk_word(q, 32'h5A);
    i_req.xfer(0, 8'h0C, 32'h0033_0000, q);
    i_req.xfer(0, 8'h0C, 32'h0077_0100, q);
    i_req.xfer(1, 8'hC0, 32'h0, q);
    chk_word(q, 32'h33);
    i_req.xfer(1, 8'hC4, 32'h0, q);
    chk_word(q, 32'h0);
    i_req.xfer(1, 8'h08, 32'h0, q);
    chk_word(q & 32'h4, 32'h4);
    i_req.xfer(0, 8'h00, 32'h4, q);
    i_req.xfer(1, 8'h08, 32'h0, q);
    chk_word(q & 32'h4, 32'h0);
    i_req.cmd(16'h0123, 8'h01, 1, 128'h0002, rcv);
    chk_rc(rcv, 8'h00);
    i_req.xfer(0, 8'h0C, 32'h0011_0000, q);
    i_req.xfer(1, 8'hC0, 32'h0, q);
    chk_word(q, 32'h5A);
    i_req.xfer(0, 8'h0C, 32'h0044_0001, q);
    i_req.cmd(16'h0456, 8'h01, 1, 128'h0002, rcv);
    chk_rc(rcv, 8'h00);
    i_req.xfer(1, 8'hE0, 32'h0, q);
    chk_word(q, 32'h44);
    i_req.xfer(1, 8'h10, 32'h0, q);
    chk_word(q, 32'h0);
    $display("awkward cases done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rc(rc, 8'h00);
    i_req.xfer(1, 8'h80, 32'h0, q);
    chk_word(q, 32'h0000_5555);
    i_req.xfer(1, 8'h08, 32'h0, q);
    chk_word(q, 32'h0);
    $display("reset case done");
    print_verdict();
  end
endmodule // test_sae_actuator_enables
